/* File: rtl/acss_pkg.sv */
// Purpose: shared constants and types of the channel sequencing block
// Assumes: 32-bit APB data, one register per aligned word
// Notes:   result views hold 10-bit samples
package acss_pkg;
    localparam int unsigned ACSS_SLOTS  = 8;
    localparam int unsigned ACSS_RES_W  = 10;

    // register byte offsets
    localparam logic [7:0] ACSS_CTRL_OFS = 8'h00;
    localparam logic [7:0] ACSS_STAT_OFS = 8'h04;
    // view windows, selected by paddr[7:5]
    localparam logic [2:0] ACSS_RJU_WIN  = 3'h2;
    localparam logic [2:0] ACSS_LJS_WIN  = 3'h3;
    localparam logic [2:0] ACSS_LJU_WIN  = 3'h4;

    // control word fields
    localparam int unsigned ACSS_SCAN_BIT  = 6;
    localparam int unsigned ACSS_SWEEP_BIT = 5;
    localparam int unsigned ACSS_EIGHT_BIT = 4;
    localparam logic [6:0]  ACSS_CTRL_RST  = 7'h00;

    // status word fields
    localparam int unsigned ACSS_DONE_BIT = 15;

    // channel codes of the reference set
    localparam logic [3:0] ACSS_CH_HIGH = 4'hC;
    localparam logic [3:0] ACSS_CH_LOW  = 4'hD;
    localparam logic [3:0] ACSS_CH_HALF = 4'hE;
    localparam logic [3:0] ACSS_CH_TEST = 4'hF;

    // last slot index of each sequence length
    localparam logic [2:0] ACSS_LAST4 = 3'h3;
    localparam logic [2:0] ACSS_LAST8 = 3'h7;

    typedef enum logic [1:0] {
        ACSS_IDLE,
        ACSS_START,
        ACSS_WAIT
    } acss_state_e;

    typedef enum logic [1:0] {
        ACSS_VIEW_RU,
        ACSS_VIEW_LS,
        ACSS_VIEW_LU
    } acss_view_e;
endpackage

/* File: rtl/acss_slot_store.sv */
// Purpose: eight result slots and their three read formats
// Assumes: one write port from the sequencer, combinational read
// Notes:   format depends only on the view asked for
module acss_slot_store
    import acss_pkg::*;
#(
    parameter int unsigned SLOTS = ACSS_SLOTS,
    parameter int unsigned RES_W = ACSS_RES_W
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // write side
    input  wire logic                     wr_en,
    input  wire logic [$clog2(SLOTS)-1:0] wr_slot,
    input  wire logic [RES_W-1:0]         wr_data,
    // read side
    input  wire logic [$clog2(SLOTS)-1:0] rd_slot,
    input  acss_view_e                    rd_view,
    output logic [15:0]                   rd_data
);
    logic [RES_W-1:0] slot_q [SLOTS];
    logic [RES_W-1:0] slot_d [SLOTS];
    logic [RES_W-1:0] sample;

    always_comb begin
        for (int i = 0; i < SLOTS; i++) begin
            slot_d[i] = slot_q[i];
        end
        if (wr_en) begin
            slot_d[wr_slot] = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                slot_q[i] <= slot_d[i];
            end
        end
    end

    // signed view: midscale is zero, so flipping the top bit gives two's complement
    always_comb begin
        sample = slot_q[rd_slot];
        unique case (rd_view)
            ACSS_VIEW_RU: rd_data = 16'({sample});
            ACSS_VIEW_LS: rd_data = 16'({~sample[RES_W-1], sample[RES_W-2:0]} << (16 - RES_W));
            ACSS_VIEW_LU: rd_data = 16'({sample} << (16 - RES_W));
            default:      rd_data = 16'h0000;
        endcase
    end
endmodule

/* File: rtl/acss_top.sv */
// Purpose: channel selection and result slot sequencing of the converter
// Assumes: converter core runs on pclk; conv_done is a one-cycle pulse
// Notes:   registers over APB, zero wait states, two-cycle transfers
//
// Decided for this implementation: the APB slave port and the register offsets.

module acss_top
    import acss_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // converter core
    output logic             conv_start,
    output logic             conv_abort,
    output logic [3:0]       channel_code,
    input  wire logic        conv_done,
    input  wire logic [9:0]  conv_result,
    // analog multiplexer selects
    output logic [7:0]       analog_select,
    output logic             high_reference_sel,
    output logic             low_reference_sel,
    output logic             half_span_sel,
    output logic             test_sel
);
    acss_state_e state_q, state_d;
    logic [6:0]  ctrl_q, ctrl_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [7:0]  flg_q, flg_d;
    logic        sqd_q, sqd_d;
    logic        first_q, first_d;
    logic        start_q, start_d;
    logic        abort_q, abort_d;
    logic [3:0]  code_q, code_d;
    logic [7:0]  asel_q, asel_d;
    logic [3:0]  rsel_q, rsel_d;
    logic        rdy_q, rdy_d;
    logic        err_q, err_d;
    logic [31:0] rdata_q, rdata_d;

    logic        setup;
    logic        xfer_done;
    logic        ctrl_wr;
    logic        view_hit;
    logic        reg_hit;
    logic        slot_rd;
    logic        slot_wr;
    logic        last_slot;
    logic [2:0]  last_idx;
    logic [15:0] view_data;
    acss_view_e  view_sel;

    // ---------------- apb decode ----------------
    assign setup     = psel && !penable;
    assign xfer_done = psel && penable && rdy_q;
    assign ctrl_wr   = xfer_done && pwrite && (paddr == ACSS_CTRL_OFS);

    always_comb begin
        view_hit = (paddr[1:0] == 2'h0);
        unique case (paddr[7:5])
            ACSS_RJU_WIN: view_sel = ACSS_VIEW_RU;
            ACSS_LJS_WIN: view_sel = ACSS_VIEW_LS;
            ACSS_LJU_WIN: view_sel = ACSS_VIEW_LU;
            default: begin
                view_sel = ACSS_VIEW_RU;
                view_hit = 1'b0;
            end
        endcase
    end

    // views are read only; a write there is refused
    assign reg_hit = (paddr == ACSS_CTRL_OFS) || (paddr == ACSS_STAT_OFS)
                   || (view_hit && !pwrite);
    assign slot_rd = xfer_done && !pwrite && view_hit;

    acss_slot_store #(
        .SLOTS (ACSS_SLOTS),
        .RES_W (ACSS_RES_W)
    ) u_slots (
        .clk     (pclk),
        .rst_n   (presetn),
        .wr_en   (slot_wr),
        .wr_slot (cnt_q),
        .wr_data (conv_result),
        .rd_slot (paddr[4:2]),
        .rd_view (view_sel),
        .rd_data (view_data)
    );

    // read data captured in setup, so the access phase needs no wait
    always_comb begin
        rdy_d   = setup;
        err_d   = setup && !reg_hit;
        rdata_d = 32'h0000_0000;
        if (setup && !pwrite) begin
            if (paddr == ACSS_CTRL_OFS) begin
                rdata_d = {25'h0000000, ctrl_q};
            end else if (paddr == ACSS_STAT_OFS) begin
                rdata_d = {16'h0000, sqd_q, 4'h0, cnt_q, flg_q};
            end else if (view_hit) begin
                rdata_d = {16'h0000, view_data};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_q   <= 1'b0;
            err_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rdy_q   <= rdy_d;
            err_q   <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // ---------------- sequencer ----------------
    assign last_idx  = ctrl_q[ACSS_EIGHT_BIT] ? ACSS_LAST8 : ACSS_LAST4;
    assign last_slot = (cnt_q == last_idx);

    // slot number maps straight into the low code bits when sweeping
    function automatic logic [3:0] acss_code(input logic [6:0] c, input logic [2:0] n);
        if (!c[ACSS_SWEEP_BIT]) begin
            return c[3:0];
        end else if (!c[ACSS_EIGHT_BIT]) begin
            return {c[3:2], n[1:0]};
        end else begin
            return {c[3], n};
        end
    endfunction

    always_comb begin
        state_d = state_q;
        ctrl_d  = ctrl_q;
        cnt_d   = cnt_q;
        flg_d   = flg_q;
        sqd_d   = sqd_q;
        first_d = first_q;
        start_d = 1'b0;
        abort_d = 1'b0;
        slot_wr = 1'b0;
        // clear by read first, so a finishing conversion below wins
        if (slot_rd) begin
            flg_d[paddr[4:2]] = 1'b0;
        end
        unique case (state_q)
            ACSS_IDLE: begin
            end
            ACSS_START: begin
                start_d = 1'b1;
                state_d = ACSS_WAIT;
            end
            ACSS_WAIT: begin
                if (conv_done) begin
                    // reserved codes stored like any other
                    slot_wr       = 1'b1;
                    flg_d[cnt_q]  = 1'b1;
                    if (last_slot) begin
                        cnt_d   = 3'h0;
                        sqd_d   = sqd_q || first_q;
                        first_d = 1'b0;
                        state_d = ctrl_q[ACSS_SCAN_BIT] ? ACSS_START : ACSS_IDLE;
                    end else begin
                        cnt_d   = cnt_q + 3'h1;
                        state_d = ACSS_START;
                    end
                end
            end
        endcase
        // a control write beats everything, including a result landing now
        if (ctrl_wr) begin
            ctrl_d  = pwdata[6:0];
            abort_d = (state_q != ACSS_IDLE);
            slot_wr = 1'b0;
            flg_d   = 8'h00;
            sqd_d   = 1'b0;
            cnt_d   = 3'h0;
            first_d = 1'b1;
            state_d = ACSS_START;
        end
    end

    // decode of the code that the next conversion will use
    always_comb begin
        code_d = acss_code(ctrl_d, cnt_d);
        asel_d = 8'h00;
        rsel_d = 4'h0;
        if (!code_d[3]) begin
            asel_d[code_d[2:0]] = 1'b1;
        end else if (code_d[2]) begin
            rsel_d[code_d[1:0]] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ACSS_IDLE;
            ctrl_q  <= ACSS_CTRL_RST;
            cnt_q   <= 3'h0;
            flg_q   <= 8'h00;
            sqd_q   <= 1'b0;
            first_q <= 1'b0;
            start_q <= 1'b0;
            abort_q <= 1'b0;
            code_q  <= 4'h0;
            // code 0 is input 0, so the select agrees with the code from reset on
            asel_q  <= 8'h01;
            rsel_q  <= 4'h0;
        end else begin
            state_q <= state_d;
            ctrl_q  <= ctrl_d;
            cnt_q   <= cnt_d;
            flg_q   <= flg_d;
            sqd_q   <= sqd_d;
            first_q <= first_d;
            start_q <= start_d;
            abort_q <= abort_d;
            code_q  <= code_d;
            asel_q  <= asel_d;
            rsel_q  <= rsel_d;
        end
    end

    assign pready             = rdy_q;
    assign pslverr            = err_q;
    assign prdata             = rdata_q;
    assign conv_start         = start_q;
    assign conv_abort         = abort_q;
    assign channel_code       = code_q;
    assign analog_select      = asel_q;
    assign high_reference_sel = rsel_q[0];
    assign low_reference_sel  = rsel_q[1];
    assign half_span_sel      = rsel_q[2];
    assign test_sel           = rsel_q[3];

    // ---------------- checks ----------------
    default clocking tick @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic done_ok;
    assign done_ok = (state_q == ACSS_WAIT) && conv_done && !ctrl_wr;

    sequence s_ctrl_write;
        ctrl_wr;
    endsequence

    sequence s_fresh_start;
        (state_q == ACSS_START) ##1 (conv_start && cnt_q == 3'h0);
    endsequence

    restart_seq_a: assert property (s_ctrl_write |=> s_fresh_start)
        else $error("control write did not restart at slot 0");

    flag_clear_a: assert property (s_ctrl_write |=> (flg_q == 8'h00) && !sqd_q)
        else $error("flags not cleared by control write");

    abort_run_a: assert property (ctrl_wr && state_q != ACSS_IDLE |=> conv_abort)
        else $error("running sequence not aborted");

    input_decode_a: assert property (!channel_code[3] |->
        analog_select == (8'h01 << channel_code[2:0]) && !high_reference_sel)
        else $error("analog input decode wrong");

    ref_decode_a: assert property (channel_code == ACSS_CH_HALF |->
        half_span_sel && analog_select == 8'h00 && !test_sel)
        else $error("reference decode wrong");

    single_code_a: assert property (conv_start && !ctrl_q[ACSS_SWEEP_BIT] |->
        channel_code == ctrl_q[3:0])
        else $error("single channel code wrong");

    group_code_a: assert property (conv_start && ctrl_q[ACSS_SWEEP_BIT]
        && !ctrl_q[ACSS_EIGHT_BIT] |-> channel_code == {ctrl_q[3:2], cnt_q[1:0]})
        else $error("four sweep code wrong");

    sweep8_code_a: assert property (conv_start && ctrl_q[ACSS_SWEEP_BIT]
        && ctrl_q[ACSS_EIGHT_BIT] |-> channel_code == {ctrl_q[3], cnt_q})
        else $error("eight sweep code wrong");

    short_wrap_a: assert property (done_ok && !ctrl_q[ACSS_EIGHT_BIT] && cnt_q == 3'h3
        |=> cnt_q == 3'h0)
        else $error("four sequence did not wrap after slot 3");

    step_next_a: assert property (done_ok && !last_slot
        |=> cnt_q == $past(cnt_q) + 3'h1 ##1 conv_start)
        else $error("sequence did not step to next slot");

    one_shot_a: assert property (done_ok && last_slot && !ctrl_q[ACSS_SCAN_BIT]
        |=> state_q == ACSS_IDLE && sqd_q)
        else $error("single sequence did not stop");

    slot_flag_a: assert property (done_ok |=> flg_q[$past(cnt_q)])
        else $error("slot flag not set on completion");

    view_left_a: assert property (setup && !pwrite && view_hit && view_sel != ACSS_VIEW_RU
        |=> prdata[5:0] == 6'h00 && prdata[31:16] == 16'h0000)
        else $error("left view low bits not zero");
endmodule

/* File: verif/acss_core_model.sv */
// Purpose: behavioural converter core facing the channel sequencer
// Assumes: one conv_done per conv_start unless conv_abort comes first, answer after 1 or 6 cycles
// Notes:   result is the channel code over a salt, so slots can be predicted
module acss_core_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // requests from the sequencer
    input  wire logic       conv_start,
    input  wire logic       conv_abort,
    input  wire logic [3:0] channel_code,
    // bench knobs
    input  wire logic       slow,
    input  wire logic [5:0] salt,
    // answer
    output logic            conv_done,
    output logic [9:0]      conv_result,
    output int              starts
);
    int         wait_q;
    logic [9:0] held_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= 0;
            held_q <= 10'h000;
            starts <= 0;
            conv_done <= 1'b0;
            conv_result <= 10'h3FF;
        end else begin
            conv_done <= 1'b0;
            // stale data outside the done pulse, never the last result
            conv_result <= ~held_q;
            if (conv_abort) begin
                wait_q <= 0;
            end else if (conv_start) begin
                wait_q <= slow ? 6 : 1;
                held_q <= {channel_code, salt};
                starts <= starts + 1;
            end else if (wait_q == 1) begin
                wait_q <= 0;
                conv_done <= 1'b1;
                conv_result <= held_q;
            end else if (wait_q > 1) begin
                wait_q <= wait_q - 1;
            end
        end
    end
endmodule

/* File: verif/tb_top.sv */
// Purpose: self-checking bench of the channel sequencing block
// Assumes: zero-wait APB slave, core model answering in 1 or 6 cycles
// Notes:   each APB transfer queues its expectation; a monitor pops and compares
module tb_top
    import acss_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        slow = 1'b0;
    logic [5:0]  salt = 6'h00;
    logic [7:0]  rnd = 8'h58;
    logic [31:0] prdata;
    logic        pready, pslverr, conv_start, conv_abort, conv_done;
    logic [3:0]  channel_code;
    logic [9:0]  conv_result;
    logic [7:0]  analog_select;
    logic        high_reference_sel, low_reference_sel, half_span_sel, test_sel;
    logic [33:0] exp_q[$];
    int          starts;
    int          aborts = 0;
    int          fail_count = 0;
    int          checks_done = 0;
    logic [6:0]  modes[9] = '{7'h05, 7'h1D, 7'h0A, 7'h20, 7'h24, 7'h28, 7'h2C, 7'h30, 7'h38};

    always #10 pclk = ~pclk;

    acss_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .conv_start, .conv_abort, .channel_code, .conv_done, .conv_result,
        .analog_select, .high_reference_sel, .low_reference_sel, .half_span_sel, .test_sel);

    acss_core_model u_core (.pclk, .presetn, .conv_start, .conv_abort, .channel_code,
        .slow, .salt, .conv_done, .conv_result, .starts);

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one idle edge first, so back-to-back calls never drive a signal twice at once
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic chk, input logic err, output logic [31:0] rd);
        @(posedge pclk);
        exp_q.push_back({chk, err, d});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count assumed: only the watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge pclk) begin
        logic [33:0] e;
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            check("error response", {31'h0, e[32]}, {31'h0, pslverr});
            if (e[33]) check("read data", e[31:0], prdata);
        end
        if (conv_start === 1'b1) check("input select", {20'h0, channel_code == ACSS_CH_TEST,
            channel_code == ACSS_CH_HALF, channel_code == ACSS_CH_LOW,
            channel_code == ACSS_CH_HIGH, channel_code < 4'h8 ? 8'h01 << channel_code : 8'h00},
            {20'h0, test_sel, half_span_sel, low_reference_sel, high_reference_sel,
            analog_select});
        if (conv_abort === 1'b1) aborts++;
    end

    task automatic run_seq(input logic [6:0] ctl);
        logic [31:0] rd;
        logic [3:0]  code;
        logic [9:0]  r;
        int          last;
        last = ctl[4] ? 7 : 3;
        apb(1'b1, ACSS_CTRL_OFS, {25'h0, ctl}, 1'b0, 1'b0, rd);
        apb(1'b0, ACSS_STAT_OFS, 32'h0, 1'b1, 1'b0, rd);
        // a sequence that never completes is caught by the watchdog
        do begin
            apb(1'b0, ACSS_STAT_OFS, 32'h0, 1'b0, 1'b0, rd);
        end while (rd[ACSS_DONE_BIT] !== 1'b1);
        apb(1'b0, ACSS_STAT_OFS, 32'h8000 | ((32'h2 << last) - 1), 1'b1, 1'b0, rd);
        for (int s = 0; s <= last; s++) begin
            code = !ctl[5] ? ctl[3:0] : ctl[4] ? {ctl[3], 3'(s)} : {ctl[3:2], 2'(s)};
            r = {code, salt};
            apb(1'b0, {ACSS_RJU_WIN, 5'(4 * s)}, {22'h0, r}, 1'b1, 1'b0, rd);
        end
        apb(1'b0, {ACSS_LJS_WIN, 5'(4 * last)}, {16'h0, ~r[9], r[8:0], 6'h0}, 1'b1, 1'b0, rd);
        apb(1'b0, {ACSS_LJU_WIN, 5'(4 * last)}, {16'h0, r, 6'h0}, 1'b1, 1'b0, rd);
        apb(1'b0, ACSS_STAT_OFS, 32'h8000, 1'b1, 1'b0, rd);
    endtask

    initial begin
        logic [31:0] rd;
        logic [6:0]  ctl;
        int          base;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ACSS_CTRL_OFS, 32'h0, 1'b1, 1'b0, rd);
        apb(1'b0, ACSS_STAT_OFS, 32'h0, 1'b1, 1'b0, rd);
        apb(1'b0, 8'h20, 32'h0, 1'b0, 1'b1, rd);
        apb(1'b1, 8'h40, 32'h0, 1'b0, 1'b1, rd);
        foreach (modes[i]) begin
            rnd = lfsr(rnd);
            slow <= i[0];
            salt <= rnd[5:0];
            // low code bits are don't-care in sweeps: fill them at random
            ctl = modes[i] | (!modes[i][5] ? 7'h0 : modes[i][4] ? {4'h0, rnd[2:0]} :
                {5'h0, rnd[1:0]});
            run_seq(ctl);
        end
        slow <= 1'b1;
        apb(1'b1, ACSS_CTRL_OFS, 32'h5B, 1'b0, 1'b0, rd);
        base = starts;
        repeat (120) @(posedge pclk);
        check("scan restarts", 32'h1, {31'h0, starts - base > 8});
        base = aborts;
        run_seq(7'h03);
        check("abort pulses", 32'h1, 32'(aborts - base));
        base = starts;
        repeat (40) @(posedge pclk);
        check("no restart", 32'(base), 32'(starts));
        tally_and_finish();
    end

    // about twenty times the expected run length
    initial begin
        #400000;
        fail_count++;
        tally_and_finish();
    end
endmodule
